// ===== rtl/mpd_top.sv
// Summary of operation
// - Secondary period is 16 bits; upper sixteen bits read zero.
// - Secondary period written below 0x0008 is used as 0x0008.
// - Periods count prescaled system clock ticks, prescale in bits 6:4.
// - Secondary trigger to the ADC when secondary count matches compare.
// - Fault select picks fault pins 1-8, comparators 1-5, or fault 15.
// - With fuse clear, I/O control writes need keys 0xABCD then 0x4321.
// - The protected write must be the very next register access.
// - Pin enables at zero leave pins to the general port logic.
// - Fault forces each pin to fault data through its polarity bit.
// - Phase delays the generator period start behind the master count.
// - Independent time base bit turns phase into the local period.
// - In independent mode the secondary duty sets the low output.
// - Alternate dead time is 14 bits on the generator time base.
// - Alternate dead time skipped when duty is zero or at least period.
// - Master count advances per prescaled tick up to master period.
module mpd_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [mpd_pkg::ADDR_W-1:0] addr_i,
   input wire logic [mpd_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [mpd_pkg::DATA_W-1:0] rdata_o,
   // Fault and comparator inputs, asynchronous
   input wire logic [mpd_pkg::NUM_FLT-1:0] fault_pins_i,
   input wire logic fault_input_fifteen_i,
   input wire logic [mpd_pkg::NUM_CMP-1:0] comparator_i,
   // Configuration fuse
   input wire logic write_lock_fuse_i,
   // Gate drive outputs
   output logic pwm_high_o,
   output logic pwm_low_o,
   output logic high_pin_owned_o,
   output logic low_pin_owned_o,
   // ADC trigger
   output logic adc_sec_trigger_o
);
   import mpd_pkg::*;

   // Registers
   logic module_enable_bit_r;
   logic [PRESC_W-1:0] clock_prescale_r;
   logic [CNT_W-1:0] master_period_value_r;
   logic [CNT_W-1:0] secondary_period_value_r;
   logic [CNT_W-1:0] secondary_event_compare_value_r;
   logic independent_time_base_r;
   logic [31:0] generator_io_control_r;
   logic [CNT_W-1:0] generator_phase_r;
   logic [CNT_W-1:0] duty_cycle_r;
   logic [CNT_W-1:0] secondary_duty_cycle_r;
   logic [DT_W-1:0] dead_time_r;
   logic [DT_W-1:0] alt_trailing_dead_time_r;
   logic [DATA_W-1:0] rdata_r;
   mpd_key_state_type key_state_r;
   // Internal
   logic [NUM_SYNC-1:0] sync1_r;
   logic [NUM_SYNC-1:0] sync2_r;
   logic [7:0] div_cnt_r;
   logic [7:0] div_limit;
   logic tick;
   logic tick_d_r;
   logic [CNT_W-1:0] mst_cnt;
   logic [CNT_W-1:0] sec_cnt;
   logic [CNT_W-1:0] loc_cnt;
   logic loc_wrap;
   logic loc_sync;
   logic [CNT_W-1:0] loc_period;
   logic [NUM_SRC-1:0] fault_src;
   logic fault_active;
   logic io_wr_ok;
   logic key_wr;
   logic raw_h;
   logic raw_h_r;
   logic [DT_W-1:0] dt_cnt_r;
   logic pp_phase_r;
   logic alt_valid;
   logic [DT_W-1:0] low_dead;
   logic high_act;
   logic low_act;
   logic pwm_high_r;
   logic pwm_low_r;
   logic adc_trig_r;
   logic [1:0] mode;
   logic fuse_sync;

   // Field view of the I/O control register, and the synchronised fuse
   assign mode = generator_io_control_r[MODE_LSB +: 2];
   assign fuse_sync = sync2_r[NUM_SYNC-1];

   // Two-stage synchronisers on every pin input, fuse included
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {write_lock_fuse_i, fault_input_fifteen_i, comparator_i, fault_pins_i};
         sync2_r <= sync1_r;
      end
   end

   // Prescaler: one tick every 2^n system clocks, n from the control field
   assign div_limit = 8'(8'h01 << clock_prescale_r) - 8'h01;
   assign tick = module_enable_bit_r & (div_cnt_r >= div_limit);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt_r <= '0;
      end else if (!module_enable_bit_r || tick) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + 8'h01;
      end
   end

   // Master time base
   mpd_timebase u_master (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .run_i(module_enable_bit_r),
      .tick_i(tick),
      .sync_i(1'b0),
      .clamp_en_i(1'b0),
      .period_i(master_period_value_r),
      .count_o(mst_cnt),
      .wrap_o()
   );

   // Secondary time base, period floored at the minimum
   mpd_timebase u_secondary (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .run_i(module_enable_bit_r),
      .tick_i(tick),
      .sync_i(1'b0),
      .clamp_en_i(1'b1),
      .period_i(secondary_period_value_r),
      .count_o(sec_cnt),
      .wrap_o()
   );

   // Local generator timer: restarted phase ticks after master start,
   // or free running on the phase value as its own period
   assign loc_sync = tick & ~independent_time_base_r & (mst_cnt == generator_phase_r);
   assign loc_period = independent_time_base_r ? generator_phase_r : master_period_value_r;

   mpd_timebase u_local (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .run_i(module_enable_bit_r),
      .tick_i(tick),
      .sync_i(loc_sync),
      .clamp_en_i(1'b0),
      .period_i(loc_period),
      .count_o(loc_cnt),
      .wrap_o(loc_wrap)
   );

   // Secondary event: count settles the clock after a tick, so compare then
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_d_r <= 1'b0;
         adc_trig_r <= 1'b0;
      end else begin
         tick_d_r <= tick;
         adc_trig_r <= tick_d_r & (sec_cnt == secondary_event_compare_value_r);
      end
   end

   // Fault source table; reserved codes read as no fault
   assign fault_src = {sync2_r[NUM_FLT+NUM_CMP], 2'b00, sync2_r[NUM_FLT +: NUM_CMP],
                       sync2_r[NUM_FLT-1:0]};
   assign fault_active = module_enable_bit_r & generator_io_control_r[FLTEN_BIT] &
                         fault_src[generator_io_control_r[FLTSEL_LSB +: FLTSEL_W]];

   // Raw duty compare and edge tracking for dead time
   assign raw_h = (loc_cnt < duty_cycle_r);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         raw_h_r <= 1'b0;
         dt_cnt_r <= '0;
      end else if (!module_enable_bit_r) begin
         raw_h_r <= 1'b0;
         dt_cnt_r <= '0;
      end else if (tick) begin
         raw_h_r <= raw_h;
         if (raw_h != raw_h_r) begin
            dt_cnt_r <= '0;
         end else if (dt_cnt_r != {DT_W{1'b1}}) begin
            dt_cnt_r <= dt_cnt_r + 14'h0001;
         end
      end
   end

   // Push-pull alternates the active output each local period
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pp_phase_r <= 1'b0;
      end else if (!module_enable_bit_r) begin
         pp_phase_r <= 1'b0;
      end else if (loc_wrap) begin
         pp_phase_r <= ~pp_phase_r;
      end
   end

   // Alternate trailing dead time only when duty lies inside the period
   assign alt_valid = (duty_cycle_r != 16'h0000) && (duty_cycle_r < loc_period);
   assign low_dead = alt_valid ? alt_trailing_dead_time_r : dead_time_r;

   // Active levels per output mode
   always_comb begin
      high_act = 1'b0;
      low_act = 1'b0;
      unique case (mode)
         MODE_COMPL: begin
            high_act = raw_h_r & (dt_cnt_r >= dead_time_r);
            low_act = ~raw_h_r & (dt_cnt_r >= low_dead);
         end
         MODE_REDUN: begin
            high_act = raw_h_r;
            low_act = raw_h_r;
         end
         MODE_PUSHPULL: begin
            high_act = raw_h_r & ~pp_phase_r;
            low_act = raw_h_r & pp_phase_r;
         end
         MODE_INDEP: begin
            high_act = raw_h_r;
            low_act = (loc_cnt < secondary_duty_cycle_r);
         end
      endcase
   end

   // Pin drive: fault data overrides, polarity bit set means active low
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwm_high_r <= 1'b0;
         pwm_low_r <= 1'b0;
      end else begin
         if (!generator_io_control_r[HPEN_BIT]) begin
            pwm_high_r <= 1'b0;
         end else if (fault_active) begin
            pwm_high_r <= generator_io_control_r[FDAT_H_BIT] ^
                          generator_io_control_r[HPOL_BIT];
         end else begin
            pwm_high_r <= (high_act & module_enable_bit_r) ^ generator_io_control_r[HPOL_BIT];
         end
         if (!generator_io_control_r[LPEN_BIT]) begin
            pwm_low_r <= 1'b0;
         end else if (fault_active) begin
            pwm_low_r <= generator_io_control_r[FDAT_L_BIT] ^
                         generator_io_control_r[LPOL_BIT];
         end else begin
            pwm_low_r <= (low_act & module_enable_bit_r) ^ generator_io_control_r[LPOL_BIT];
         end
      end
   end

   // Pin ownership passes to the port logic while enables are clear
   assign high_pin_owned_o = generator_io_control_r[HPEN_BIT];
   assign low_pin_owned_o = generator_io_control_r[LPEN_BIT];
   // Gated by the enable too, so a cleared enable never leaves a stale level
   assign pwm_high_o = pwm_high_r & generator_io_control_r[HPEN_BIT];
   assign pwm_low_o = pwm_low_r & generator_io_control_r[LPEN_BIT];
   assign adc_sec_trigger_o = adc_trig_r;

   // Unlock sequencer; every access, read or write, advances or breaks it.
   // Not atomic: an interrupt handler touching registers breaks the chain.
   assign key_wr = wr_en_i & (addr_i == OFS_KEY);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         key_state_r <= KEY_IDLE;
      end else if (wr_en_i || rd_en_i) begin
         unique case (key_state_r)
            KEY_IDLE: begin
               key_state_r <= (key_wr && wdata_i[15:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
            end
            KEY_HALF: begin
               if (key_wr && wdata_i[15:0] == KEY_SECOND) begin
                  key_state_r <= KEY_OPEN;
               end else if (key_wr && wdata_i[15:0] == KEY_FIRST) begin
                  key_state_r <= KEY_HALF;
               end else begin
                  key_state_r <= KEY_IDLE;
               end
            end
            KEY_OPEN: begin
               key_state_r <= (key_wr && wdata_i[15:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
            end
         endcase
      end
   end

   // Fuse set leaves the I/O control open at all times
   assign io_wr_ok = fuse_sync | (key_state_r == KEY_OPEN);

   // Time base control and period registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         module_enable_bit_r <= 1'b0;
         clock_prescale_r <= '0;
         master_period_value_r <= MST_PER_RST;
         secondary_period_value_r <= SEC_PER_RST;
         secondary_event_compare_value_r <= '0;
      end else if (wr_en_i) begin
         if (addr_i == OFS_TB_CTRL) begin
            module_enable_bit_r <= wdata_i[TB_EN_BIT];
            clock_prescale_r <= wdata_i[PRESC_LSB +: PRESC_W];
         end
         if (addr_i == OFS_MST_PER) begin
            master_period_value_r <= wdata_i[CNT_W-1:0];
         end
         if (addr_i == OFS_SEC_PER) begin
            secondary_period_value_r <= wdata_i[CNT_W-1:0];
         end
         if (addr_i == OFS_SEC_CMP) begin
            secondary_event_compare_value_r <= wdata_i[CNT_W-1:0];
         end
      end
   end

   // Generator registers; I/O control guarded by the unlock chain
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         independent_time_base_r <= 1'b0;
         generator_io_control_r <= '0;
         generator_phase_r <= '0;
         duty_cycle_r <= '0;
         secondary_duty_cycle_r <= '0;
         dead_time_r <= '0;
         alt_trailing_dead_time_r <= '0;
      end else if (wr_en_i) begin
         if (addr_i == OFS_GEN_CTRL) begin
            independent_time_base_r <= wdata_i[IND_TB_BIT];
         end
         if (addr_i == OFS_IO_CTRL && io_wr_ok) begin
            generator_io_control_r <= wdata_i & IO_CTRL_MASK;
         end
         if (addr_i == OFS_PHASE) begin
            generator_phase_r <= wdata_i[CNT_W-1:0];
         end
         if (addr_i == OFS_DUTY) begin
            duty_cycle_r <= wdata_i[CNT_W-1:0];
         end
         if (addr_i == OFS_SEC_DUTY) begin
            secondary_duty_cycle_r <= wdata_i[CNT_W-1:0];
         end
         if (addr_i == OFS_DEAD) begin
            dead_time_r <= wdata_i[DT_W-1:0];
         end
         if (addr_i == OFS_ALT_DEAD) begin
            alt_trailing_dead_time_r <= wdata_i[DT_W-1:0];
         end
      end
   end

   // Read data stands the cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= '0;
      end else if (rd_en_i) begin
         unique case (addr_i)
            OFS_TB_CTRL: rdata_r <= 32'({module_enable_bit_r, 8'h00, clock_prescale_r, 4'h0});
            OFS_MST_PER: rdata_r <= {16'h0000, master_period_value_r};
            OFS_MST_TMR: rdata_r <= {16'h0000, mst_cnt};
            OFS_SEC_PER: rdata_r <= {16'h0000, secondary_period_value_r};
            OFS_SEC_CMP: rdata_r <= {16'h0000, secondary_event_compare_value_r};
            OFS_SEC_TMR: rdata_r <= {16'h0000, sec_cnt};
            OFS_GEN_CTRL: rdata_r <= 32'({independent_time_base_r, 9'h000});
            OFS_IO_CTRL: rdata_r <= generator_io_control_r;
            OFS_PHASE: rdata_r <= {16'h0000, generator_phase_r};
            OFS_DUTY: rdata_r <= {16'h0000, duty_cycle_r};
            OFS_SEC_DUTY: rdata_r <= {16'h0000, secondary_duty_cycle_r};
            OFS_DEAD: rdata_r <= {18'h00000, dead_time_r};
            OFS_ALT_DEAD: rdata_r <= {18'h00000, alt_trailing_dead_time_r};
            OFS_STATUS: rdata_r <= {28'h0000000, fuse_sync, key_state_r == KEY_OPEN,
                                    key_state_r == KEY_HALF, fault_active};
            default: rdata_r <= '0;
         endcase
      end
   end

   assign rdata_o = rdata_r;
endmodule // mpd_top

// ===== rtl/mpd_pkg.sv
package mpd_pkg;
   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte addresses
   localparam logic [7:0] OFS_TB_CTRL = 8'h00;
   localparam logic [7:0] OFS_MST_PER = 8'h04;
   localparam logic [7:0] OFS_MST_TMR = 8'h08;
   localparam logic [7:0] OFS_SEC_PER = 8'h0C;
   localparam logic [7:0] OFS_SEC_CMP = 8'h10;
   localparam logic [7:0] OFS_SEC_TMR = 8'h14;
   localparam logic [7:0] OFS_GEN_CTRL = 8'h18;
   localparam logic [7:0] OFS_IO_CTRL = 8'h1C;
   localparam logic [7:0] OFS_PHASE = 8'h20;
   localparam logic [7:0] OFS_DUTY = 8'h24;
   localparam logic [7:0] OFS_SEC_DUTY = 8'h28;
   localparam logic [7:0] OFS_DEAD = 8'h2C;
   localparam logic [7:0] OFS_ALT_DEAD = 8'h30;
   localparam logic [7:0] OFS_KEY = 8'h34;
   localparam logic [7:0] OFS_STATUS = 8'h38;
   // Time base control fields
   localparam int TB_EN_BIT = 15;
   localparam int PRESC_LSB = 4;
   localparam int PRESC_W = 3;
   // Generator control fields
   localparam int IND_TB_BIT = 9;
   // I/O control fields
   localparam int HPEN_BIT = 15;
   localparam int LPEN_BIT = 14;
   localparam int HPOL_BIT = 13;
   localparam int LPOL_BIT = 12;
   localparam int MODE_LSB = 10;
   localparam int FLTSEL_LSB = 19;
   localparam int FLTSEL_W = 4;
   localparam int FLTEN_BIT = 18;
   localparam int FDAT_H_BIT = 5;
   localparam int FDAT_L_BIT = 4;
   localparam logic [31:0] IO_CTRL_MASK = 32'h007CFC30;
   // Output modes
   localparam logic [1:0] MODE_COMPL = 2'h0;
   localparam logic [1:0] MODE_REDUN = 2'h1;
   localparam logic [1:0] MODE_PUSHPULL = 2'h2;
   localparam logic [1:0] MODE_INDEP = 2'h3;
   // Field widths
   localparam int CNT_W = 16;
   localparam int DT_W = 14;
   // Limits and keys
   localparam logic [15:0] MIN_PERIOD = 16'h0008;
   localparam logic [15:0] KEY_FIRST = 16'hABCD;
   localparam logic [15:0] KEY_SECOND = 16'h4321;
   // Reset values
   localparam logic [15:0] SEC_PER_RST = 16'h4020;
   localparam logic [15:0] MST_PER_RST = 16'h0000;
   // Fault sources: 8 fault pins, 5 comparators, one extra fault pin
   localparam int NUM_FLT = 8;
   localparam int NUM_CMP = 5;
   localparam int NUM_SRC = 16;
   localparam int NUM_SYNC = 15;
   // Unlock sequencer states
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} mpd_key_state_type;
endpackage : mpd_pkg

// ===== rtl/mpd_timebase.sv
module mpd_timebase (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic sync_i,
   input wire logic clamp_en_i,
   input wire logic [mpd_pkg::CNT_W-1:0] period_i,
   // Status
   output logic [mpd_pkg::CNT_W-1:0] count_o,
   output logic wrap_o
);
   import mpd_pkg::*;

   logic [CNT_W-1:0] eff_period;
   logic [CNT_W-1:0] count_r;

   // Short periods are lifted to the floor when asked to
   assign eff_period = (clamp_en_i && period_i < MIN_PERIOD) ? MIN_PERIOD : period_i;
   assign wrap_o = run_i & tick_i & (sync_i | (count_r >= eff_period));
   assign count_o = count_r;

   // Count up one per prescaled tick, back to zero at the period
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_r <= '0;
      end else if (!run_i) begin
         count_r <= '0;
      end else if (wrap_o) begin
         count_r <= '0;
      end else if (tick_i) begin
         count_r <= count_r + 16'h0001;
      end
   end
endmodule // mpd_timebase

// ===== verif/mpd_top_properties.sv
module mpd_top_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [mpd_pkg::ADDR_W-1:0] addr_i,
   input wire logic [mpd_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [mpd_pkg::DATA_W-1:0] rdata_o,
   // Fault sources and fuse
   input wire logic [mpd_pkg::NUM_FLT-1:0] fault_pins_i,
   input wire logic fault_input_fifteen_i,
   input wire logic [mpd_pkg::NUM_CMP-1:0] comparator_i,
   input wire logic write_lock_fuse_i,
   // Pins and trigger
   input wire logic pwm_high_o,
   input wire logic pwm_low_o,
   input wire logic high_pin_owned_o,
   input wire logic low_pin_owned_o,
   input wire logic adc_sec_trigger_o
);
   import mpd_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [15:0] per_r;
   logic [15:0] lim;
   logic key1;
   logic key2;
   logic io_wr;
   // Shadow of the secondary period, so the timer bound needs no peek inside
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         per_r <= SEC_PER_RST;
      end else if (wr_en_i && addr_i == OFS_SEC_PER) begin
         per_r <= wdata_i[15:0];
      end
   end
   // Decoded bus events
   assign lim = (per_r < MIN_PERIOD) ? MIN_PERIOD : per_r;
   assign key1 = wr_en_i && addr_i == OFS_KEY && wdata_i[15:0] == KEY_FIRST;
   assign key2 = wr_en_i && addr_i == OFS_KEY && wdata_i[15:0] == KEY_SECOND;
   assign io_wr = wr_en_i && addr_i == OFS_IO_CTRL;

   property p_high_port; !high_pin_owned_o |-> !pwm_high_o; endproperty
   a_high_port: assert property (p_high_port) else $error("high pin driven");
   property p_low_port; !low_pin_owned_o |-> !pwm_low_o; endproperty
   a_low_port: assert property (p_low_port) else $error("low pin driven");
   property p_trig_pulse; adc_sec_trigger_o |=> !adc_sec_trigger_o; endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
   property p_per_upper; rd_en_i && addr_i == OFS_SEC_PER |=> rdata_o[31:16] == 16'h0000;
   endproperty
   a_per_upper: assert property (p_per_upper) else $error("period upper bits");
   property p_cmp_upper; rd_en_i && addr_i == OFS_SEC_CMP |=> rdata_o[31:16] == 16'h0000;
   endproperty
   a_cmp_upper: assert property (p_cmp_upper) else $error("compare upper bits");
   property p_alt_upper; rd_en_i && addr_i == OFS_ALT_DEAD |=> rdata_o[31:14] == 18'h00000;
   endproperty
   a_alt_upper: assert property (p_alt_upper) else $error("dead time upper bits");
   property p_floor; rd_en_i && addr_i == OFS_SEC_TMR |=> rdata_o[15:0] <= $past(lim);
   endproperty
   a_floor: assert property (p_floor) else $error("timer beyond period");
   property p_unlock; (!write_lock_fuse_i && key1) ##1 key2 ##1 io_wr
      |=> ##1 high_pin_owned_o == $past(wdata_i[HPEN_BIT], 2); endproperty
   a_unlock: assert property (p_unlock) else $error("unlocked write lost");
   property p_broken; (!write_lock_fuse_i && key1) ##1 key2 ##1 rd_en_i ##2 io_wr
      |=> ##1 high_pin_owned_o == $past(high_pin_owned_o, 2); endproperty
   a_broken: assert property (p_broken) else $error("late write taken");
endmodule // mpd_top_chk

bind mpd_top mpd_top_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
   .fault_pins_i(fault_pins_i), .fault_input_fifteen_i(fault_input_fifteen_i),
   .comparator_i(comparator_i), .write_lock_fuse_i(write_lock_fuse_i),
   .pwm_high_o(pwm_high_o), .pwm_low_o(pwm_low_o), .high_pin_owned_o(high_pin_owned_o),
   .low_pin_owned_o(low_pin_owned_o), .adc_sec_trigger_o(adc_sec_trigger_o));

// ===== verif/mpd_gate_model.sv
module mpd_gate_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Gate pins and ADC trigger
   input wire logic pwm_high_i,
   input wire logic pwm_low_i,
   input wire logic adc_trig_i,
   // Observations
   output int gap_o,
   output int shoot_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cyc;
   int last;
   // ADC side takes each one-cycle pulse; spacing gives the secondary period
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cyc <= 0;
         last <= 0;
         gap_o <= 0;
         shoot_o <= 0;
      end else begin
         cyc <= cyc + 1;
         if (adc_trig_i) begin
            gap_o <= cyc - last;
            last <= cyc;
         end
         // Both gates on would short the bridge leg
         if (pwm_high_i && pwm_low_i) begin
            shoot_o <= shoot_o + 1;
         end
      end
   end
endmodule // mpd_gate_model

// ===== verif/tb.sv
`define CHK(a, e) \
   begin \
      compares++; \
      if ((a) !== (e)) begin \
         fail_count++; \
         $display("wrong value at %0t: got %h want %h", $time, (a), (e)); \
      end \
   end

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mpd_pkg::*;
   logic clk_i;
   logic arst_n_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i;
   logic wr_en_i;
   logic rd_en_i;
   logic [DATA_W-1:0] rdata_o;
   logic [NUM_FLT-1:0] fault_pins_i;
   logic fault_input_fifteen_i;
   logic [NUM_CMP-1:0] comparator_i;
   logic write_lock_fuse_i;
   logic pwm_high_o;
   logic pwm_low_o;
   logic high_pin_owned_o;
   logic low_pin_owned_o;
   logic adc_sec_trigger_o;
   int gap;
   int shoot;
   int fail_count = 0;
   int compares = 0;
   int seed = 12;
   int exp_gap;
   int per_tab[3] = '{3, 3, 20};
   int psc_tab[3] = '{0, 2, 0};
   logic [31:0] v;
   logic [15:0] src;
   logic flt;
   int hi;
   int lo;

   // Free-running system clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   mpd_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o), .fault_pins_i(fault_pins_i),
      .fault_input_fifteen_i(fault_input_fifteen_i), .comparator_i(comparator_i),
      .write_lock_fuse_i(write_lock_fuse_i), .pwm_high_o(pwm_high_o), .pwm_low_o(pwm_low_o),
      .high_pin_owned_o(high_pin_owned_o), .low_pin_owned_o(low_pin_owned_o),
      .adc_sec_trigger_o(adc_sec_trigger_o));
   mpd_gate_model u_far (.clk_i(clk_i), .arst_n_i(arst_n_i), .pwm_high_i(pwm_high_o),
      .pwm_low_i(pwm_low_o), .adc_trig_i(adc_sec_trigger_o), .gap_o(gap), .shoot_o(shoot));

   // Write strobe stays up so key words can go back to back
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      rd_en_i <= 1'b0;
      wr_en_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
   endtask
   task automatic idle();
      wr_en_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Read data valid from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wr_en_i <= 1'b0;
      rd_en_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      @(negedge clk_i);
      q = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      rd(a, q);
      `CHK(q, e);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Hang guard, far beyond the fewer than 700 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      {addr_i, wdata_i, wr_en_i, rd_en_i} = '0;
      {fault_pins_i, fault_input_fifteen_i, comparator_i} = '0;
      write_lock_fuse_i = 1'b0;
      arst_n_i = 1'b0;
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      rdc(OFS_SEC_PER, 32'h00004020);
      wr(OFS_SEC_PER, 32'hFFFF1234);
      rdc(OFS_SEC_PER, 32'h00001234);
      wr(OFS_ALT_DEAD, 32'hFFFFFFFF);
      rdc(OFS_ALT_DEAD, 32'h00003FFF);
      wr(OFS_SEC_CMP, 32'hFFFF0005);
      rdc(OFS_SEC_CMP, 32'h00000005);
      rdc(8'h3C, 32'h00000000);
      $display("test registers done");
      // Fuse held low since reset, so the key is required
      wr(OFS_IO_CTRL, 32'h0000C000);
      rdc(OFS_IO_CTRL, 32'h00000000);
      wr(OFS_KEY, 32'h0000ABCD);
      wr(OFS_KEY, 32'h00004321);
      wr(OFS_IO_CTRL, 32'h0000C000);
      rdc(OFS_IO_CTRL, 32'h0000C000);
      `CHK(high_pin_owned_o, 1'b1);
      wr(OFS_KEY, 32'h0000ABCD);
      wr(OFS_KEY, 32'h00004321);
      rd(OFS_STATUS, v);
      `CHK(v, 32'h00000004);
      wr(OFS_IO_CTRL, 32'h00000000);
      rdc(OFS_IO_CTRL, 32'h0000C000);
      $display("test unlock done");
      for (int i = 0; i < 3; i++) begin
         exp_gap = ((per_tab[i] < MIN_PERIOD ? MIN_PERIOD : per_tab[i]) + 1) << psc_tab[i];
         wr(OFS_TB_CTRL, 32'h00000000);
         wr(OFS_SEC_PER, 32'(per_tab[i]));
         wr(OFS_TB_CTRL, 32'h00008000 | (32'(psc_tab[i]) << PRESC_LSB));
         idle();
         repeat (3 * exp_gap + 20) @(posedge clk_i);
         rd(OFS_SEC_TMR, v);
         `CHK(gap, exp_gap);
      end
      $display("test timer done");
      // Select changed only while stopped, as software must
      write_lock_fuse_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      for (int c = 0; c < 16; c++) begin
         wr(OFS_TB_CTRL, 32'h00000000);
         wr(OFS_IO_CTRL, 32'h0004DC30 | (32'(c) << FLTSEL_LSB));
         wr(OFS_TB_CTRL, 32'h00008000);
         idle();
         repeat (3) begin
            v = $random(seed);
            fault_pins_i <= v[7:0];
            comparator_i <= v[12:8];
            fault_input_fifteen_i <= v[13];
            repeat (5) @(posedge clk_i);
            src = {fault_input_fifteen_i, 2'b00, comparator_i, fault_pins_i};
            flt = src[c];
            `CHK(pwm_high_o, flt);
            `CHK(pwm_low_o, !flt);
         end
      end
      `CHK(shoot, 0);
      $display("test fault done");
      // Phase as local period 9: ten counts, duty 4 on high, secondary duty 6 on low
      wr(OFS_TB_CTRL, 32'h00000000);
      wr(OFS_IO_CTRL, 32'h0000CC00);
      wr(OFS_ALT_DEAD, 32'h00000000);
      wr(OFS_GEN_CTRL, 32'h00000200);
      wr(OFS_PHASE, 32'h00000009);
      wr(OFS_DUTY, 32'h00000004);
      wr(OFS_SEC_DUTY, 32'h00000006);
      wr(OFS_TB_CTRL, 32'h00008000);
      idle();
      repeat (30) @(posedge clk_i);
      hi = 0;
      lo = 0;
      // Sampled mid-cycle, away from the edge that moves the pins
      repeat (10) begin
         @(negedge clk_i);
         hi += int'(pwm_high_o);
         lo += int'(pwm_low_o);
      end
      `CHK(hi, 4);
      `CHK(lo, 6);
      $display("test local period done");
      tally_and_finish();
   end
endmodule // tb
